/* File: src/slcls_defs.svh */
`ifndef SLCLS_DEFS_SVH
`define SLCLS_DEFS_SVH

`define SLCLS_NUM_LANES      8
`define SLCLS_WORD_BITS      40
`define SLCLS_FIFO_DEPTH     4
`define SLCLS_LAST_BIT       6'h27

`define SLCLS_A_IF_PWR       12'h200
`define SLCLS_A_LANE_PD      12'h201
`define SLCLS_A_CAL_A        12'h2a7
`define SLCLS_A_CAL_B        12'h2ae
`define SLCLS_A_MAP0         12'h308
`define SLCLS_A_MAP1         12'h309
`define SLCLS_A_MAP2         12'h30a
`define SLCLS_A_MAP3         12'h30b
`define SLCLS_A_DUAL         12'h30e
`define SLCLS_A_MODE0        12'h30f
`define SLCLS_A_MODE1        12'h310
`define SLCLS_A_STATUS       12'h311
`define SLCLS_A_LANE_SYNC    12'h312
`define SLCLS_A_LINK0_PAR    12'h313

`define SLCLS_RST_IF_PWR     8'h01
`define SLCLS_RST_MAP        {8'h3e, 8'h2c, 8'h1a, 8'h08}
`define SLCLS_MAP_MASK       8'h3f
`define SLCLS_SEL_BITS       3

`define SLCLS_PWR_BIT        0
`define SLCLS_CAL_BIT        0
`define SLCLS_OVF_BIT        0
`define SLCLS_CAL_A_LANES    8'hc3
`define SLCLS_CAL_B_LANES    8'h3c
`define SLCLS_LINK1_BASE     4'h4
`define SLCLS_DUAL_MIN_MODE  4'h4

`define SLCLS_CLK_PERIOD_NS  50
`define SLCLS_CAL_TIME_NS    3200
`define SLCLS_CAL_CYCLES     ((`SLCLS_CAL_TIME_NS + `SLCLS_CLK_PERIOD_NS - 1) / `SLCLS_CLK_PERIOD_NS)

`endif

/* File: src/slcls_pkg.sv */
`default_nettype none
`include "slcls_defs.svh"

package slcls_pkg;

    typedef logic [`SLCLS_NUM_LANES-1:0][`SLCLS_WORD_BITS-1:0] slcls_lanes_type;

    typedef struct packed {
        logic       vld;
        logic [3:0] m;
        logic [3:0] l;
        logic [1:0] s;
        logic [2:0] f;
    } slcls_mode_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } slcls_reg_req_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } slcls_reg_rsp_type;

    typedef struct packed {
        logic [7:0]        ser_s1;
        logic [7:0]        ser_s2;
        logic [7:0]        cgs_s1;
        logic [7:0]        cgs_s2;
        logic [7:0]        if_pwr;
        logic [7:0]        lane_pd;
        logic [7:0]        cal_a;
        logic [7:0]        cal_b;
        logic [3:0][7:0]   lane_map;
        logic              dual;
        logic [3:0]        mode0;
        logic [3:0]        mode1;
        logic              ovf;
        logic [5:0]        bit_cnt;
        slcls_lanes_type   shreg;
        slcls_lanes_type   word;
        logic              push;
        logic [6:0]        cal_cnt_a;
        logic [6:0]        cal_cnt_b;
        logic [7:0]        term_act;
        logic              sync0_n;
        logic              sync1_n;
        slcls_reg_rsp_type rsp;
    } slcls_state_type;

endpackage

`default_nettype wire

/* File: src/slcls_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module slcls_fifo #(
    parameter int WIDTH = 320,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [DEPTH-1:0]            vld;
    } slcls_fifo_state_type;

    slcls_fifo_state_type q;
    slcls_fifo_state_type d;

    // head always sits in slot 0 so the outputs are plain flops
    always_comb begin
        logic done;
        done = 1'b0;
        d = q;
        if (q.vld[0] && out_ready) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                d.mem[i] = q.mem[i+1];
                d.vld[i] = q.vld[i+1];
            end
            d.vld[DEPTH-1] = 1'b0;
        end
        // full refuses a push even when a pop frees a slot: simpler, still honest
        if (in_valid && !q.vld[DEPTH-1]) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (!d.vld[i] && !done) begin
                    d.mem[i] = in_data;
                    d.vld[i] = 1'b1;
                    done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign in_ready  = !q.vld[DEPTH-1];
    assign out_valid = q.vld[0];
    assign out_data  = q.mem[0];

    a_fifo_hold: assert property (@(posedge clk) disable iff (!rst_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("fifo head changed while stalled");

    a_fifo_full: assert property (@(posedge clk) disable iff (!rst_n)
        in_valid && !in_ready && !out_ready |=> $stable(q.vld))
        else $error("fifo took a word while full");

endmodule

`default_nettype wire

/* File: src/slcls_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "slcls_defs.svh"

module slcls_top (
    input  wire logic                         ref_clk,
    input  wire logic                         rst_n,
    input  wire logic [`SLCLS_NUM_LANES-1:0]  serial_lane_input,
    input  wire logic [`SLCLS_NUM_LANES-1:0]  lane_code_group_sync,
    input  wire slcls_pkg::slcls_reg_req_type reg_req,
    output var  slcls_pkg::slcls_reg_rsp_type reg_rsp,
    output logic                              link0_sync_output_n,
    output logic                              link1_sync_output_n,
    output logic                              serial_interface_off,
    output logic [`SLCLS_NUM_LANES-1:0]       lane_power_down,
    output logic [`SLCLS_NUM_LANES-1:0]       term_cal_active,
    output logic                              out_valid,
    input  wire logic                         out_ready,
    output var  slcls_pkg::slcls_lanes_type   out_lanes
);
    import slcls_pkg::*;

    localparam int NL = `SLCLS_NUM_LANES;
    localparam int WB = `SLCLS_WORD_BITS;

    slcls_state_type q;
    slcls_state_type d;

    slcls_mode_type                          p0;
    slcls_mode_type                          p1;
    logic                                    v0;
    logic                                    v1;
    logic                                    req0;
    logic                                    req1;
    logic [NL-1:0]                           lane_ok;
    logic [NL-1:0]                           mem0;
    logic [NL-1:0]                           mem1;
    logic [NL-1:0][`SLCLS_SEL_BITS-1:0]      src;
    logic                                    fifo_in_ready;

    // mode table: vld, M, L, S, F
    function automatic slcls_mode_type mode_params(input logic [3:0] id);
        slcls_mode_type p;
        p = '0;
        case (id)
            4'h0: p = {1'b1, 4'h4, 4'h8, 2'h1, 3'h1};
            4'h1: p = {1'b1, 4'h4, 4'h8, 2'h2, 3'h2};
            4'h2: p = {1'b1, 4'h4, 4'h4, 2'h1, 3'h2};
            4'h3: p = {1'b1, 4'h4, 4'h2, 2'h1, 3'h4};
            4'h4: p = {1'b1, 4'h2, 4'h4, 2'h1, 3'h1};
            4'h5: p = {1'b1, 4'h2, 4'h4, 2'h2, 3'h2};
            4'h6: p = {1'b1, 4'h2, 4'h2, 2'h1, 3'h2};
            4'h7: p = {1'b1, 4'h2, 4'h1, 2'h1, 3'h4};
            4'h9: p = {1'b1, 4'h1, 4'h2, 2'h1, 3'h1};
            4'ha: p = {1'b1, 4'h1, 4'h1, 2'h1, 3'h2};
            default: p = '0;
        endcase
        return p;
    endfunction

    function automatic logic [`SLCLS_SEL_BITS-1:0] lane_src(
        input logic [3:0][7:0] map,
        input int              y
    );
        logic [7:0] pair;
        pair = map[y/2];
        if (y % 2 == 0) begin
            return pair[`SLCLS_SEL_BITS-1:0];
        end
        return pair[2*`SLCLS_SEL_BITS-1:`SLCLS_SEL_BITS];
    endfunction

    always_comb begin
        d = q;
        p0 = mode_params(q.mode0);
        p1 = mode_params(q.mode1);
        // unknown modes and single-only modes in dual use hold the link in resync
        v0 = p0.vld && (!q.dual || q.mode0 >= `SLCLS_DUAL_MIN_MODE);
        v1 = p1.vld && (q.mode1 >= `SLCLS_DUAL_MIN_MODE);

        d.ser_s1 = serial_lane_input;
        d.ser_s2 = q.ser_s1;
        d.cgs_s1 = lane_code_group_sync;
        d.cgs_s2 = q.cgs_s1;

        // one bit per lane per clock, earliest bit ends in bit 0
        for (int k = 0; k < NL; k++) begin
            d.shreg[k] = {q.ser_s2[k], q.shreg[k][WB-1:1]};
        end
        d.bit_cnt = (q.bit_cnt == `SLCLS_LAST_BIT) ? 6'h00 : q.bit_cnt + 6'h01;

        d.push = 1'b0;
        for (int y = 0; y < NL; y++) begin
            src[y] = lane_src(q.lane_map, y);
            lane_ok[y] = q.cgs_s2[src[y]] && !q.lane_pd[src[y]];
            mem0[y] = (4'(y) < p0.l) && (!q.dual || 4'(y) < `SLCLS_LINK1_BASE);
            mem1[y] = q.dual && (4'(y) >= `SLCLS_LINK1_BASE)
                      && (4'(y) < p1.l + `SLCLS_LINK1_BASE);
            if (q.bit_cnt == `SLCLS_LAST_BIT) begin
                // any physical word may feed any logical lane, repeats allowed
                d.word[y] = q.lane_pd[src[y]] ? '0 : d.shreg[src[y]];
            end
        end
        if (q.bit_cnt == `SLCLS_LAST_BIT) begin
            d.push = !q.if_pwr[`SLCLS_PWR_BIT];
        end

        // the far end answers a request with sync characters until released
        req0 = q.if_pwr[`SLCLS_PWR_BIT] || !v0 || |(mem0 & ~lane_ok);
        req1 = q.dual && (q.if_pwr[`SLCLS_PWR_BIT] || !v1 || |(mem1 & ~lane_ok));
        d.sync0_n = !req0;
        d.sync1_n = !req1;

        if (q.cal_cnt_a != 7'h00) begin
            d.cal_cnt_a = q.cal_cnt_a - 7'h01;
        end
        if (q.cal_cnt_b != 7'h00) begin
            d.cal_cnt_b = q.cal_cnt_b - 7'h01;
        end

        if (reg_req.wr) begin
            case (reg_req.addr)
                `SLCLS_A_IF_PWR: d.if_pwr = reg_req.wdata;
                `SLCLS_A_LANE_PD: d.lane_pd = reg_req.wdata;
                `SLCLS_A_CAL_A: begin
                    if (reg_req.wdata[`SLCLS_CAL_BIT] && !q.cal_a[`SLCLS_CAL_BIT]) begin
                        d.cal_cnt_a = 7'(`SLCLS_CAL_CYCLES);
                    end
                    d.cal_a = reg_req.wdata;
                end
                `SLCLS_A_CAL_B: begin
                    if (reg_req.wdata[`SLCLS_CAL_BIT] && !q.cal_b[`SLCLS_CAL_BIT]) begin
                        d.cal_cnt_b = 7'(`SLCLS_CAL_CYCLES);
                    end
                    d.cal_b = reg_req.wdata;
                end
                `SLCLS_A_MAP0: d.lane_map[0] = reg_req.wdata & `SLCLS_MAP_MASK;
                `SLCLS_A_MAP1: d.lane_map[1] = reg_req.wdata & `SLCLS_MAP_MASK;
                `SLCLS_A_MAP2: d.lane_map[2] = reg_req.wdata & `SLCLS_MAP_MASK;
                `SLCLS_A_MAP3: d.lane_map[3] = reg_req.wdata & `SLCLS_MAP_MASK;
                `SLCLS_A_DUAL: d.dual = reg_req.wdata[0];
                `SLCLS_A_MODE0: d.mode0 = reg_req.wdata[3:0];
                `SLCLS_A_MODE1: d.mode1 = reg_req.wdata[3:0];
                `SLCLS_A_STATUS: begin
                    if (reg_req.wdata[`SLCLS_OVF_BIT]) begin
                        d.ovf = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // the line cannot be stalled, so a full buffer drops the word; set beats clear
        if (q.push && !fifo_in_ready) begin
            d.ovf = 1'b1;
        end

        d.term_act = ({NL{d.cal_cnt_a != 7'h00}} & `SLCLS_CAL_A_LANES)
                   | ({NL{d.cal_cnt_b != 7'h00}} & `SLCLS_CAL_B_LANES);

        d.rsp.valid = reg_req.rd;
        d.rsp.data = 8'h00;
        if (reg_req.rd) begin
            case (reg_req.addr)
                `SLCLS_A_IF_PWR: d.rsp.data = q.if_pwr;
                `SLCLS_A_LANE_PD: d.rsp.data = q.lane_pd;
                `SLCLS_A_CAL_A: d.rsp.data = q.cal_a;
                `SLCLS_A_CAL_B: d.rsp.data = q.cal_b;
                `SLCLS_A_MAP0: d.rsp.data = q.lane_map[0];
                `SLCLS_A_MAP1: d.rsp.data = q.lane_map[1];
                `SLCLS_A_MAP2: d.rsp.data = q.lane_map[2];
                `SLCLS_A_MAP3: d.rsp.data = q.lane_map[3];
                `SLCLS_A_DUAL: d.rsp.data = {7'h00, q.dual};
                `SLCLS_A_MODE0: d.rsp.data = {4'h0, q.mode0};
                `SLCLS_A_MODE1: d.rsp.data = {4'h0, q.mode1};
                `SLCLS_A_STATUS: begin
                    d.rsp.data = {1'b0, q.cal_cnt_b != 7'h00, q.cal_cnt_a != 7'h00,
                                  !q.sync1_n, !q.sync0_n, q.dual && !v1, !v0, q.ovf};
                end
                `SLCLS_A_LANE_SYNC: d.rsp.data = q.cgs_s2;
                // host derives lane rate from M and L
                `SLCLS_A_LINK0_PAR: d.rsp.data = {p0.m, p0.l};
                default: d.rsp.data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '0;
            q.if_pwr <= `SLCLS_RST_IF_PWR;
            q.lane_map <= `SLCLS_RST_MAP;
            q.sync1_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    slcls_fifo #(
        .WIDTH (NL * WB),
        .DEPTH (`SLCLS_FIFO_DEPTH)
    ) u_fifo (
        .clk       (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (q.push),
        .in_ready  (fifo_in_ready),
        .in_data   (q.word),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_lanes)
    );

    assign reg_rsp              = q.rsp;
    assign link0_sync_output_n  = q.sync0_n;
    assign link1_sync_output_n  = q.sync1_n;
    assign serial_interface_off = q.if_pwr[`SLCLS_PWR_BIT];
    assign lane_power_down      = q.lane_pd;
    assign term_cal_active      = q.term_act;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_lane0_lost;
        (!lane_code_group_sync[q.lane_map[0][`SLCLS_SEL_BITS-1:0]]
         && $stable(q.lane_map) && $stable(q.lane_pd)) [*3];
    endsequence

    sequence s_all_synced;
        (&lane_code_group_sync && q.lane_pd == 8'h00 && !q.if_pwr[0] && !q.dual
         && q.mode0 == 4'h0) [*3];
    endsequence

    sequence s_cal_a_start;
        reg_req.wr && reg_req.addr == `SLCLS_A_CAL_A && reg_req.wdata[0] && !q.cal_a[0];
    endsequence

    a_map_reset: assert property (!$past(rst_n) |-> q.lane_map == `SLCLS_RST_MAP)
        else $error("lane map not identity after reset");

    for (genvar y = 0; y < NL; y++) begin : g_xbar
        localparam int LO = (y % 2) * `SLCLS_SEL_BITS;
        // expected source read from the raw map field, not from the select function
        a_crossbar_route: assert property (q.push |-> q.word[y] ==
            ($past(q.lane_pd[q.lane_map[y/2][LO +: `SLCLS_SEL_BITS]]) ? {WB{1'b0}}
             : q.shreg[$past(q.lane_map[y/2][LO +: `SLCLS_SEL_BITS])]))
            else $error("logical lane word not from selected physical lane");
    end

    a_sync_request: assert property (s_lane0_lost |=> !link0_sync_output_n)
        else $error("no sync request after lane loss");

    a_sync_release: assert property (s_all_synced |=> link0_sync_output_n)
        else $error("sync request held with all lanes synced");

    a_single_link1: assert property (!q.dual |=> link1_sync_output_n)
        else $error("second sync output active in single link");

    a_dual_modes: assert property (q.dual && q.mode0 < `SLCLS_DUAL_MIN_MODE
        |=> !link0_sync_output_n)
        else $error("single-only mode accepted in dual link");

    a_mode8_unused: assert property (q.mode0 == 4'h8 |=> !link0_sync_output_n)
        else $error("mode 8 accepted");

    a_if_power: assert property (reg_req.wr && reg_req.addr == `SLCLS_A_IF_PWR
        |=> serial_interface_off == $past(reg_req.wdata[0]))
        else $error("interface power bit not applied");

    a_lane_pd: assert property (reg_req.wr && reg_req.addr == `SLCLS_A_LANE_PD
        |=> lane_power_down == $past(reg_req.wdata))
        else $error("lane power down mask not applied");

    a_cal_start_a: assert property (s_cal_a_start |=>
        ((term_cal_active & `SLCLS_CAL_A_LANES) == `SLCLS_CAL_A_LANES) [*8])
        else $error("calibration a did not start on rising bit");

    a_word_cadence: assert property (q.push |-> ##40 (q.push || $past(q.if_pwr[0])))
        else $error("word cadence not forty clocks");

endmodule

`default_nettype wire

/* File: testbench/slcls_tx_model.sv */
`timescale 1ns/1ps
`default_nettype none

// far-side transmitter: one bit per lane per clock, aligned to the receiver word counter
module slcls_tx_model (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       link0_sync_output_n,
    input  wire logic       link1_sync_output_n,
    input  wire logic [7:0] link1_lanes,
    input  wire logic [7:0] lost,
    output logic [7:0]      serial_lane_input,
    output logic [7:0]      lane_code_group_sync
);
    localparam logic [39:0] COMMA = {4{10'b0011111010}};
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic [5:0] idx;

    function automatic logic data_bit(input int x, input logic [5:0] i);
        logic [39:0] w;
        w = {8{x[2:0], 2'b01}};
        return w[i];
    endfunction

    // the receiver has two sync stages, so the pin runs two bits ahead of its counter
    assign cnt_d = (!rst_n || cnt_q == 6'h27) ? 6'h00 : cnt_q + 6'h01;
    assign idx   = (cnt_d > 6'h25) ? cnt_d - 6'h26 : cnt_d + 6'h02;

    always_ff @(posedge ref_clk) begin
        cnt_q                <= cnt_d;
        lane_code_group_sync <= ~lost;
        for (int x = 0; x < 8; x++) begin
            // a link under request gets comma characters, never data
            if (link1_lanes[x] ? !link1_sync_output_n : !link0_sync_output_n) begin
                serial_lane_input[x] <= COMMA[idx];
            end else begin
                serial_lane_input[x] <= data_bit(x, idx);
            end
        end
    end
endmodule

`default_nettype wire

/* File: testbench/serial_lane_crossbar_link_setup_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_lane_crossbar_link_setup_tb;
    import slcls_pkg::*;
    localparam logic [7:0] ML [0:10] = '{8'h48, 8'h48, 8'h44, 8'h42, 8'h24, 8'h24,
                                         8'h22, 8'h21, 8'h00, 8'h12, 8'h11};
    logic              ref_clk = 1'b0;
    logic              rst_n = 1'b0;
    slcls_reg_req_type reg_req = '0;
    slcls_reg_rsp_type reg_rsp;
    logic [7:0]        ser;
    logic [7:0]        cgs;
    logic              sync0_n;
    logic              sync1_n;
    logic              if_off;
    logic [7:0]        lane_pd;
    logic [7:0]        cal_act;
    logic              out_valid;
    logic              out_ready = 1'b0;
    slcls_lanes_type   out_lanes;
    logic [7:0]        link1_lanes = '0;
    logic [7:0]        lost = '0;
    logic [7:0]        rd;
    int                num_errors = 0;
    int                n_tests = 0;

    always #25 ref_clk = ~ref_clk;

    slcls_top u_dut (
        .ref_clk              (ref_clk),
        .rst_n                (rst_n),
        .serial_lane_input    (ser),
        .lane_code_group_sync (cgs),
        .reg_req              (reg_req),
        .reg_rsp              (reg_rsp),
        .link0_sync_output_n  (sync0_n),
        .link1_sync_output_n  (sync1_n),
        .serial_interface_off (if_off),
        .lane_power_down      (lane_pd),
        .term_cal_active      (cal_act),
        .out_valid            (out_valid),
        .out_ready            (out_ready),
        .out_lanes            (out_lanes)
    );

    slcls_tx_model u_tx (
        .ref_clk              (ref_clk),
        .rst_n                (rst_n),
        .link0_sync_output_n  (sync0_n),
        .link1_sync_output_n  (sync1_n),
        .link1_lanes          (link1_lanes),
        .lost                 (lost),
        .serial_lane_input    (ser),
        .lane_code_group_sync (cgs)
    );

    function automatic logic [39:0] lane_word(input int x);
        return {8{x[2:0], 2'b01}};
    endfunction

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        reg_req <= '0;
    endtask

    // answer is registered on the taking edge itself and stands for one cycle
    task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        reg_req <= '0;
        #1;
        check(40'(reg_rsp.valid), 40'h1);
        d = reg_rsp.data;
    endtask

    task automatic wait_sync(input logic e0, input logic e1);
        int n;
        n = 0;
        // step off the edge so a value launched by it is settled
        #1;
        while ({sync0_n, sync1_n} !== {e0, e1} && n < 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(40'({sync0_n, sync1_n}), 40'({e0, e1}));
        if ({sync0_n, sync1_n} !== {e0, e1}) finish_test();
    endtask

    task automatic t_reset();
        for (int k = 0; k < 4; k++) begin
            reg_rd(12'h308 + 12'(k), rd);
            check(40'(rd), 40'(8'h08 + 8'(8'h12 * k)));
        end
        reg_rd(12'h200, rd);
        check(40'(rd), 40'h01);
        check(40'({if_off, sync0_n, sync1_n}), 40'h5);
        reg_rd(12'h2aa, rd);
        check(40'(rd), 40'h00);
    endtask

    task automatic t_power();
        reg_wr(12'h200, 8'h00);
        #1;
        check(40'(if_off), 40'h0);
        reg_wr(12'h201, 8'ha5);
        #1;
        check(40'(lane_pd), 40'ha5);
        reg_rd(12'h201, rd);
        check(40'(rd), 40'ha5);
        reg_wr(12'h201, 8'h00);
    endtask

    task automatic t_cal();
        int n;
        reg_wr(12'h2aa, 8'hb7);
        reg_wr(12'h2ab, 8'h87);
        reg_wr(12'h2b1, 8'hb7);
        reg_wr(12'h2b2, 8'h87);
        reg_wr(12'h2a7, 8'h01);
        #1;
        check(40'(cal_act), 40'hc3);
        n = 0;
        while (cal_act != 8'h00 && n < 100) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(40'(n), 40'd64);
        if (n == 100) finish_test();
        // bit already high: no rising edge, so no new run
        reg_wr(12'h2a7, 8'h01);
        #1;
        check(40'(cal_act), 40'h00);
        reg_wr(12'h2ae, 8'h01);
        #1;
        check(40'(cal_act), 40'h3c);
    endtask

    task automatic t_modes();
        for (int m = 0; m < 11; m++) begin
            reg_wr(12'h30f, 8'(m));
            reg_rd(12'h313, rd);
            check(40'(rd), 40'(ML[m]));
            reg_rd(12'h311, rd);
            check(40'(rd[1]), 40'(m == 8));
        end
        reg_wr(12'h30e, 8'h01);
        for (int m = 0; m < 11; m++) begin
            reg_wr(12'h30f, 8'(m));
            reg_rd(12'h311, rd);
            check(40'(rd[1]), 40'(m < 4 || m == 8));
        end
        reg_wr(12'h30e, 8'h00);
        reg_wr(12'h30f, 8'h00);
    endtask

    task automatic t_sync();
        wait_sync(1'b1, 1'b1);
        @(posedge ref_clk) lost <= 8'h20;
        wait_sync(1'b0, 1'b1);
        reg_rd(12'h312, rd);
        check(40'(rd), 40'hdf);
        reg_rd(12'h311, rd);
        check(40'(rd[4:3]), 40'h1);
        @(posedge ref_clk) lost <= 8'h00;
        wait_sync(1'b1, 1'b1);
        reg_wr(12'h30e, 8'h01);
        reg_wr(12'h30f, 8'h04);
        reg_wr(12'h310, 8'h04);
        @(posedge ref_clk) link1_lanes <= 8'hf0;
        wait_sync(1'b1, 1'b1);
        @(posedge ref_clk) lost <= 8'h20;
        wait_sync(1'b1, 1'b0);
        @(posedge ref_clk) lost <= 8'h01;
        wait_sync(1'b0, 1'b1);
        @(posedge ref_clk) lost <= 8'h00;
        wait_sync(1'b1, 1'b1);
        reg_wr(12'h30f, 8'h08);
        wait_sync(1'b0, 1'b1);
        reg_wr(12'h30e, 8'h00);
        reg_wr(12'h30f, 8'h00);
        @(posedge ref_clk) link1_lanes <= 8'h00;
    endtask

    task automatic t_data();
        int pops;
        int src;
        // reversed crossbar; mode 9 uses logical 0 and 1 only, so lane 0 may sleep
        for (int k = 0; k < 4; k++) begin
            reg_wr(12'h308 + 12'(k), {2'b00, 3'(6 - 2 * k), 3'(7 - 2 * k)});
            reg_rd(12'h308 + 12'(k), rd);
            check(40'(rd), 40'({2'b00, 3'(6 - 2 * k), 3'(7 - 2 * k)}));
        end
        reg_wr(12'h30f, 8'h09);
        reg_wr(12'h201, 8'h01);
        wait_sync(1'b1, 1'b1);
        @(posedge ref_clk) out_ready <= 1'b1;
        repeat (100) @(posedge ref_clk);
        // earlier runs left the sticky overflow set; clear it while draining
        reg_wr(12'h311, 8'h01);
        reg_rd(12'h311, rd);
        check(40'(rd[0]), 40'h0);
        @(posedge ref_clk) out_ready <= 1'b0;
        repeat (200) @(posedge ref_clk);
        reg_rd(12'h311, rd);
        check(40'(rd[0]), 40'h1);
        for (int y = 0; y < 8; y++) begin
            src = 7 - y;
            check(out_lanes[y], (src == 0) ? 40'h0 : lane_word(src));
        end
        @(posedge ref_clk) out_ready <= 1'b1;
        pops = 0;
        repeat (4) begin
            #1;
            pops += int'(out_valid === 1'b1);
            @(posedge ref_clk);
        end
        out_ready <= 1'b0;
        check(40'(pops), 40'd4);
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_power();
        t_cal();
        t_modes();
        t_sync();
        t_data();
        finish_test();
    end
endmodule

`default_nettype wire
